// file: rtl/dior_pkg.sv
// Purpose: shared constants for the digital io routing block
// Assumes: 100 MHz controller clock, 32-bit input and output words
// Notes: selector codes and bit positions are fixed by the io map
package dior_pkg;

	// timing
	localparam int unsigned DIOR_CLK_HZ = 100000000;
	localparam int unsigned DIOR_SAMPLE_MS = 1;
	localparam int unsigned DIOR_SAMPLE_CYCLES = DIOR_CLK_HZ / 1000 * DIOR_SAMPLE_MS;
	localparam int unsigned DIOR_LED_HALF_MS = 250;
	localparam int unsigned DIOR_LED_HALF_TICKS = DIOR_LED_HALF_MS / DIOR_SAMPLE_MS;

	//////////////////////////////////////////////////////////////////////////////////////////
	// raw input vector layout
	localparam int unsigned DIOR_NUM_PHYS_IN = 16;
	localparam int unsigned DIOR_RAW_W = 23;
	localparam int unsigned DIOR_RAW_PHYS_LSB = 0;
	localparam int unsigned DIOR_RAW_HALL_LSB = 16;
	localparam int unsigned DIOR_RAW_ENC_LSB = 19;
	localparam int unsigned DIOR_RAW_NET_BIT = 22;
	localparam logic [22:0] DIOR_RAW_RESET = 23'h000000;

	//////////////////////////////////////////////////////////////////////////////////////////
	// word layout
	localparam int unsigned DIOR_WORD_W = 32;
	localparam int unsigned DIOR_LEVEL_LSB = 16;
	localparam int unsigned DIOR_BRAKE_BIT = 0;
	localparam int unsigned DIOR_INTERLOCK_BIT = 3;
	localparam int unsigned DIOR_NUM_OUT = 2;
	localparam logic [31:0] DIOR_WORD_RESET = 32'h00000000;
	localparam logic [15:0] DIOR_REACTION_RESET = 16'h0000;

	//////////////////////////////////////////////////////////////////////////////////////////
	// input selector codes
	localparam int unsigned DIOR_SEL_W = 8;
	localparam int unsigned DIOR_SEL_INV_BIT = 7;
	localparam logic [6:0] DIOR_SRC_ZERO = 7'h00;
	localparam logic [6:0] DIOR_SRC_PHYS_FIRST = 7'h01;
	localparam logic [6:0] DIOR_SRC_PHYS_LAST = 7'h10;
	localparam logic [6:0] DIOR_SRC_HALL_U = 7'h41;
	localparam logic [6:0] DIOR_SRC_HALL_V = 7'h42;
	localparam logic [6:0] DIOR_SRC_HALL_W = 7'h43;
	localparam logic [6:0] DIOR_SRC_ENC_A = 7'h44;
	localparam logic [6:0] DIOR_SRC_ENC_B = 7'h45;
	localparam logic [6:0] DIOR_SRC_ENC_I = 7'h46;
	localparam logic [6:0] DIOR_SRC_NET = 7'h48;

	//////////////////////////////////////////////////////////////////////////////////////////
	// output route selector layout
	localparam int unsigned DIOR_ROUTE_W = 16;
	localparam int unsigned DIOR_ROUTE_SRC_LSB = 8;
	localparam int unsigned DIOR_ROUTE_CTL_INV_BIT = 7;
	localparam logic [7:0] DIOR_OSRC_ONE = 8'h00;
	localparam logic [7:0] DIOR_OSRC_ZERO = 8'h01;

	// led control field
	localparam int unsigned DIOR_LED_GREEN_BIT = 0;
	localparam int unsigned DIOR_LED_RED_BIT = 1;

	// interlock states
	typedef enum logic [1:0] {
		DIOR_IL_OFF = 2'b00,
		DIOR_IL_OK = 2'b01,
		DIOR_IL_FAULT = 2'b10
	} dior_il_e;

endpackage

// file: rtl/dior_lvl_if.sv
// Purpose: carries the sample tick and the filtered input levels
// Assumes: one clock domain
// Notes: core drives the tick, filter returns levels
`timescale 1ns/1ps
`default_nettype none
interface dior_lvl_if #(
	parameter int unsigned W = 23
);
	logic tick;
	logic [W-1:0] level;

	modport core (output tick, input level);
	modport filt (input tick, output level);
endinterface
`default_nettype wire

// file: rtl/dior_in_filter.sv
// Purpose: synchronise and deglitch the digital input pins
// Assumes: tick pulses once per sample period
// Notes: a level is taken only when two successive samples agree
`timescale 1ns/1ps
`default_nettype none
module dior_in_filter #(
	parameter int unsigned W = 23
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// pins
	input wire logic [W-1:0] raw_i,
	// core side
	dior_lvl_if.filt lvl
);

	typedef struct packed {
		logic [W-1:0] sync1;
		logic [W-1:0] sync2;
		logic [W-1:0] last;
		logic [W-1:0] stable;
	} dior_filt_s;

	dior_filt_s s;
	dior_filt_s next_s;

	always_comb begin
		next_s = s;
		next_s.sync1 = raw_i;
		next_s.sync2 = s.sync1;
		if (lvl.tick) begin
			next_s.last = s.sync2; // see RQ17
			// pulses shorter than one period never meet two equal samples
			next_s.stable = (s.sync2 & ~(s.sync2 ^ s.last)) | (s.stable & (s.sync2 ^ s.last)); // see RQ17
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign lvl.level = s.stable;

endmodule
`default_nettype wire

// file: rtl/dior_out_calc.sv
// Purpose: compute the applied output bit pattern
// Assumes: inputs are stable registered configuration
// Notes: pure logic, registered by the caller on the sample tick
`timescale 1ns/1ps
`default_nettype none
module dior_out_calc #(
	parameter int unsigned NUM_OUT = 2
) (
	// command and configuration
	input wire logic [31:0] dout_word_i,
	input wire logic route_en_i,
	input wire logic [NUM_OUT*16-1:0] route_sel_i,
	input wire logic [31:0] force_en_i,
	input wire logic [31:0] force_val_i,
	input wire logic [31:0] polarity_i,
	// result
	output logic [31:0] applied_o
);

	// control bit index beyond the word gates from zero
	function automatic logic ctl_bit(input logic [31:0] word, input logic [6:0] idx);
		logic r;
		r = 1'b0;
		if (idx < 7'(dior_pkg::DIOR_WORD_W)) begin
			r = word[idx[4:0]];
		end
		return r;
	endfunction

	logic [31:0] cmd;
	logic [31:0] value;
	logic [31:0] used;
	logic [15:0] sel;
	logic src;
	logic gate;

	always_comb begin
		cmd = dout_word_i; // see RQ8 see RQ9
		used = '0;
		used[dior_pkg::DIOR_BRAKE_BIT] = 1'b1;
		sel = '0;
		src = 1'b0;
		gate = 1'b0;
		for (int k = 0; k < NUM_OUT; k++) begin
			used[dior_pkg::DIOR_LEVEL_LSB + k] = 1'b1;
			if (route_en_i) begin // see RQ15
				sel = route_sel_i[k*16 +: 16];
				// encoder and pwm sources are not built here and read as zero
				src = (sel[15:8] == dior_pkg::DIOR_OSRC_ONE); // see RQ14
				gate = ctl_bit(dout_word_i, sel[6:0]) ^ sel[dior_pkg::DIOR_ROUTE_CTL_INV_BIT]; // see RQ14 see RQ16
				cmd[dior_pkg::DIOR_LEVEL_LSB + k] = src & gate;
			end
		end
		value = (force_en_i & force_val_i) | (~force_en_i & cmd); // see RQ11
		applied_o = (value ^ polarity_i) & used; // see RQ10 see RQ12
	end

endmodule
`default_nettype wire

// file: rtl/dior_top.sv
// Purpose: digital input crossbar, interlock and output stage
// Assumes: configuration ports are held steady by the controller
// Notes: everything except the leds and the fault trigger pulse is recomputed once per sample tick
//
// Notes on behaviour
// RQ1 - one input selector per input word bit
// RQ2 - code zero is 0, codes 1-16 physical
// RQ3 - hall, encoder and network status codes
// RQ4 - selector bit 7 inverts the source
// RQ5 - interlock bit low forces error and reaction
// RQ6 - interlock acts only when mask bit 3
// RQ7 - crossbar only when routing enabled, else fixed
// RQ8 - output k from word bit 16+k
// RQ9 - low word bits special, bit 0 brake
// RQ10 - polarity bit selects open or closed logic
// RQ11 - override mask replaces commanded output value
// RQ12 - readback shows applied output pattern
// RQ13 - led bits enable green and red flashing
// RQ14 - route selector: source high, control index low
// RQ15 - output routing only when routing enabled
// RQ16 - route selector bit 7 inverts control bit
// RQ17 - sample once per millisecond, drop short pulses
// RQ18 - unlisted selector codes give constant zero
// RQ19 - recompute everything on each sample tick; the leds are recomputed every cycle
`timescale 1ns/1ps
`default_nettype none
module dior_top #(
	parameter int unsigned TICK_CYCLES = dior_pkg::DIOR_SAMPLE_CYCLES,
	parameter int unsigned LED_HALF_TICKS = dior_pkg::DIOR_LED_HALF_TICKS,
	parameter int unsigned NUM_OUT = dior_pkg::DIOR_NUM_OUT
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// input pins
	input wire logic [15:0] phys_in_i,
	input wire logic [2:0] hall_in_i,
	input wire logic [2:0] enc_in_i,
	input wire logic net_active_i,
	// input configuration
	input wire logic in_route_en_i,
	input wire logic [255:0] input_source_selectors_i,
	input wire logic [15:0] in_func_en_i,
	// interlock and error
	input wire logic [15:0] fault_reaction_option_i,
	input wire logic fault_ack_i,
	input wire logic ctrl_error_i,
	// output configuration
	input wire logic [31:0] digital_output_word_i,
	input wire logic [31:0] out_polarity_i,
	input wire logic [31:0] out_force_en_i,
	input wire logic [31:0] out_force_val_i,
	input wire logic out_route_en_i,
	input wire logic [NUM_OUT*16-1:0] output_route_selectors_i,
	input wire logic [1:0] led_ctrl_i,
	// input results
	output logic [31:0] digital_input_word_o,
	output logic motion_permit_o,
	output logic interlock_error_o,
	output logic fault_trigger_o,
	output logic [15:0] fault_reaction_o,
	// output results
	output logic [31:0] out_applied_o,
	output logic brake_o,
	output logic [NUM_OUT-1:0] out_pin_o,
	output logic [NUM_OUT-1:0] out_pin_oe_o,
	output logic led_green_o,
	output logic led_red_o
);

	localparam int unsigned CNT_W = $clog2(TICK_CYCLES + 1);
	localparam int unsigned LED_W = $clog2(LED_HALF_TICKS + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TICK_CYCLES - 1);
	localparam logic [LED_W-1:0] LED_LAST = LED_W'(LED_HALF_TICKS - 1);

	// the input word is a special function half and a level half of equal width
	localparam int unsigned LVL_LSB = dior_pkg::DIOR_LEVEL_LSB;
	localparam int unsigned NUM_PHYS = dior_pkg::DIOR_NUM_PHYS_IN;
	// applied resets to zero, so the pins start pulled low to agree with the readback
	localparam logic [NUM_OUT-1:0] OE_RESET = ~dior_pkg::DIOR_WORD_RESET[LVL_LSB +: NUM_OUT];

	typedef struct packed {
		logic [CNT_W-1:0] tick_cnt;
		logic tick;
		logic [31:0] din;
		dior_pkg::dior_il_e il;
		logic il_err;
		logic motion_permit;
		logic trigger;
		logic [15:0] reaction;
		logic [31:0] applied;
		logic brake;
		logic [NUM_OUT-1:0] pin_oe;
		logic [LED_W-1:0] led_cnt;
		logic blink;
		logic led_g;
		logic led_r;
	} dior_top_s;

	//////////////////////////////////////////////////////////////////////////////////////////
	// crossbar source pick
	function automatic logic pick_src(input logic [7:0] code, input logic [22:0] lv);
		logic [6:0] base;
		logic hit;
		logic v;
		base = code[6:0];
		hit = 1'b1;
		v = 1'b0;
		if (base == dior_pkg::DIOR_SRC_ZERO) begin
			v = 1'b0; // see RQ2
		end else if (base >= dior_pkg::DIOR_SRC_PHYS_FIRST && base <= dior_pkg::DIOR_SRC_PHYS_LAST) begin
			v = lv[dior_pkg::DIOR_RAW_PHYS_LSB + 4'(base - 7'h01)]; // see RQ2
		end else if (base >= dior_pkg::DIOR_SRC_HALL_U && base <= dior_pkg::DIOR_SRC_HALL_W) begin
			v = lv[dior_pkg::DIOR_RAW_HALL_LSB + 2'(base - dior_pkg::DIOR_SRC_HALL_U)]; // see RQ3
		end else if (base >= dior_pkg::DIOR_SRC_ENC_A && base <= dior_pkg::DIOR_SRC_ENC_I) begin
			v = lv[dior_pkg::DIOR_RAW_ENC_LSB + 2'(base - dior_pkg::DIOR_SRC_ENC_A)]; // see RQ3
		end else if (base == dior_pkg::DIOR_SRC_NET) begin
			v = lv[dior_pkg::DIOR_RAW_NET_BIT]; // see RQ3
		end else begin
			hit = 1'b0; // see RQ18
		end
		// unlisted codes stay zero even with the invert bit set
		return hit & (v ^ code[dior_pkg::DIOR_SEL_INV_BIT]); // see RQ4
	endfunction

	// selector byte that feeds input word bit n
	function automatic logic [7:0] sel_code(input logic [255:0] sels, input int unsigned n);
		return sels[n*8 +: 8];
	endfunction

	//////////////////////////////////////////////////////////////////////////////////////////
	// input filter
	dior_lvl_if #(.W(dior_pkg::DIOR_RAW_W)) lvl ();

	logic [22:0] raw;
	// bit order follows the raw layout constants of the package
	assign raw = {net_active_i, enc_in_i, hall_in_i, phys_in_i};
	// every pin, status included, ages through the same filter

	dior_in_filter #(
		.W(dior_pkg::DIOR_RAW_W)
	) u_filter (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.raw_i(raw),
		.lvl(lvl.filt)
	);

	//////////////////////////////////////////////////////////////////////////////////////////
	// output calculation
	logic [31:0] calc_applied;

	dior_out_calc #(
		.NUM_OUT(NUM_OUT)
	) u_out_calc (
		.dout_word_i(digital_output_word_i),
		.route_en_i(out_route_en_i),
		.route_sel_i(output_route_selectors_i),
		.force_en_i(out_force_en_i),
		.force_val_i(out_force_val_i),
		.polarity_i(out_polarity_i),
		.applied_o(calc_applied)
	);

	//////////////////////////////////////////////////////////////////////////////////////////
	// state
	dior_top_s s;
	dior_top_s next_s;
	logic [31:0] next_din;
	logic il_bit;
	logic il_en;
	logic err_any;

	assign lvl.tick = s.tick;

	//////////////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_s = s;
		next_din = '0;
		il_bit = 1'b0;
		il_en = in_func_en_i[dior_pkg::DIOR_INTERLOCK_BIT]; // see RQ6
		err_any = 1'b0;
		next_s.trigger = 1'b0;
		// tick generator: the first tick comes TICK_CYCLES cycles after reset
		next_s.tick = (s.tick_cnt == CNT_LAST); // see RQ17
		next_s.tick_cnt = next_s.tick ? '0 : CNT_W'(s.tick_cnt + 1'b1);

		// input word, low half: special function bits from the crossbar when routed, else gated by their enables
		for (int n = 0; n < LVL_LSB; n++) begin
			if (in_route_en_i) begin // see RQ7
				next_din[n] = pick_src(sel_code(input_source_selectors_i, n), lvl.level); // see RQ1
			end else begin
				next_din[n] = lvl.level[n] & in_func_en_i[n]; // see RQ7
			end
		end

		// high half: crossbar picks when routed, else plain levels of the physical inputs
		for (int n = 0; n < NUM_PHYS; n++) begin
			if (in_route_en_i) begin // see RQ7
				next_din[LVL_LSB + n] = pick_src(
					sel_code(input_source_selectors_i, LVL_LSB + n), lvl.level); // see RQ1
			end else begin
				next_din[LVL_LSB + n] = lvl.level[dior_pkg::DIOR_RAW_PHYS_LSB + n]; // see RQ7
			end
		end

		if (s.tick) begin
			// results of this sample
			next_s.din = next_din; // see RQ19
			// output stage
			next_s.applied = calc_applied; // see RQ19
			next_s.brake = calc_applied[dior_pkg::DIOR_BRAKE_BIT]; // see RQ9
			for (int k = 0; k < NUM_OUT; k++) begin
				// open drain: a low level is driven, a high level is released
				next_s.pin_oe[k] = ~calc_applied[dior_pkg::DIOR_LEVEL_LSB + k]; // see RQ8
			end

			// interlock
			il_bit = next_din[dior_pkg::DIOR_INTERLOCK_BIT];
			unique case (s.il)
				dior_pkg::DIOR_IL_OFF: begin
					if (il_en) begin // see RQ6
						next_s.il = il_bit ? dior_pkg::DIOR_IL_OK : dior_pkg::DIOR_IL_FAULT; // see RQ5
						next_s.trigger = ~il_bit; // see RQ5
					end
				end
				dior_pkg::DIOR_IL_OK: begin
					if (!il_en) begin // see RQ6
						next_s.il = dior_pkg::DIOR_IL_OFF;
					end else if (!il_bit) begin
						next_s.il = dior_pkg::DIOR_IL_FAULT; // see RQ5
						next_s.trigger = 1'b1; // see RQ5
					end
				end
				dior_pkg::DIOR_IL_FAULT: begin
					// the error state holds until acknowledged with the release back or the interlock disabled
					if (fault_ack_i && (il_bit || !il_en)) begin
						next_s.il = dior_pkg::DIOR_IL_OFF;
					end
				end
				default: begin
					next_s.il = dior_pkg::DIOR_IL_OFF;
				end
			endcase
			// frozen at entry so a later change cannot alter a stop in progress
			if (next_s.trigger) begin
				next_s.reaction = fault_reaction_option_i; // see RQ5
			end
			next_s.motion_permit = (next_s.il != dior_pkg::DIOR_IL_FAULT); // see RQ5
			next_s.il_err = (next_s.il == dior_pkg::DIOR_IL_FAULT); // see RQ5

			// led flashing
			// the blink phase runs freely; enabling an led does not restart it
			if (s.led_cnt == LED_LAST) begin
				next_s.led_cnt = '0;
				next_s.blink = ~s.blink;
			end else begin
				next_s.led_cnt = LED_W'(s.led_cnt + 1'b1);
			end
		end

		// leds lag the error state by one cycle, far below what the eye resolves
		err_any = (s.il == dior_pkg::DIOR_IL_FAULT) | ctrl_error_i;
		next_s.led_g = led_ctrl_i[dior_pkg::DIOR_LED_GREEN_BIT] & ~err_any & s.blink; // see RQ13
		next_s.led_r = led_ctrl_i[dior_pkg::DIOR_LED_RED_BIT] & err_any & s.blink; // see RQ13
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			s <= '0;
			s.din <= dior_pkg::DIOR_WORD_RESET;
			s.applied <= dior_pkg::DIOR_WORD_RESET;
			s.reaction <= dior_pkg::DIOR_REACTION_RESET;
			s.il <= dior_pkg::DIOR_IL_OFF;
			s.motion_permit <= 1'b1;
			s.pin_oe <= OE_RESET; // see RQ12
		end else begin
			s <= next_s;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// outputs
	// input results
	assign digital_input_word_o = s.din;
	assign motion_permit_o = s.motion_permit;
	assign interlock_error_o = s.il_err;
	assign fault_trigger_o = s.trigger;
	assign fault_reaction_o = s.reaction;
	// output results
	assign out_applied_o = s.applied;
	assign brake_o = s.brake;
	// open-drain data is always low; only the enable moves
	assign out_pin_o = '0;
	assign out_pin_oe_o = s.pin_oe;
	assign led_green_o = s.led_g;
	assign led_red_o = s.led_r;

endmodule
`default_nettype wire

// file: testbench/dior_pins_model.sv
// Purpose: pins around the routing block
// Assumes: bench sets all input pin levels at once
// Notes: output pins are open drain with a pull-up
`timescale 1ns/1ps
`default_nettype none
module dior_pins_model (
	// levels set by the bench
	input wire logic [22:0] lvl_i,
	// drive from the block
	input wire logic [1:0] pin_i,
	input wire logic [1:0] pin_oe_i,
	// pins seen by the block
	output logic [15:0] phys_o,
	output logic [2:0] hall_o,
	output logic [2:0] enc_o,
	output logic net_o,
	// resolved output pins
	output logic [1:0] pin_lvl_o
);
	assign phys_o = lvl_i[15:0];
	assign hall_o = lvl_i[18:16];
	assign enc_o = lvl_i[21:19];
	assign net_o = lvl_i[22];
	// released pin floats to the pull-up, never to the last value
	assign pin_lvl_o[0] = pin_oe_i[0] ? pin_i[0] : 1'b1;
	assign pin_lvl_o[1] = pin_oe_i[1] ? pin_i[1] : 1'b1;
endmodule
`default_nettype wire

// file: testbench/dior_assertions.sv
// Purpose: port checks for the routing block
// Assumes: one clock, sync active-low reset
// Notes: outputs other than the leds and the fault trigger pulse move only one cycle after a sample tick
`timescale 1ns/1ps
`default_nettype none
module dior_assertions #(
	parameter int unsigned TICK_CYCLES = 8,
	parameter int unsigned NUM_OUT = 2
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// watched inputs
	input wire logic [15:0] in_func_en_i,
	input wire logic [15:0] fault_reaction_option_i,
	input wire logic fault_ack_i,
	input wire logic ctrl_error_i,
	input wire logic [1:0] led_ctrl_i,
	// watched outputs
	input wire logic [31:0] digital_input_word_o,
	input wire logic motion_permit_o,
	input wire logic interlock_error_o,
	input wire logic fault_trigger_o,
	input wire logic [15:0] fault_reaction_o,
	input wire logic [31:0] out_applied_o,
	input wire logic brake_o,
	input wire logic [NUM_OUT-1:0] out_pin_o,
	input wire logic [NUM_OUT-1:0] out_pin_oe_o,
	input wire logic led_green_o,
	input wire logic led_red_o
);
	logic [63:0] prev;
	logic [31:0] still;
	// cycles since the last change of either word
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			prev <= 64'h0;
			still <= 32'h0;
		end else begin
			prev <= {digital_input_word_o, out_applied_o};
			still <= ({digital_input_word_o, out_applied_o} != prev) ? 32'h0 : still + 32'h1;
		end
	end
	////////////////////////////////
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_entry;
		interlock_error_o && !motion_permit_o && !digital_input_word_o[3]
			&& $past(in_func_en_i[3]) && fault_reaction_o == $past(fault_reaction_option_i);
	endsequence
	sequence s_pulse;
		fault_trigger_o ##1 !fault_trigger_o;
	endsequence
	brake_follow_a: assert property (brake_o == out_applied_o[0])
		else $error("brake differs from applied bit 0");
	applied_reserved_a: assert property ((out_applied_o & ~(32'h1 |
		(((32'h1 << NUM_OUT) - 32'h1) << 16))) == 32'h0) else $error("reserved applied bit set");
	pin_drive_a: assert property (out_pin_o == '0 &&
		out_pin_oe_o == ~out_applied_o[16 +: NUM_OUT]) else $error("pin drive wrong");
	fault_entry_a: assert property (fault_trigger_o |-> s_entry)
		else $error("fault entry state wrong");
	trigger_pulse_a: assert property (fault_trigger_o |-> s_pulse)
		else $error("fault trigger longer than one cycle");
	permit_error_a: assert property (motion_permit_o == !interlock_error_o)
		else $error("permit and error disagree");
	fault_exit_a: assert property ($fell(interlock_error_o) && $past(rst_b_i) |->
		$past(fault_ack_i)) else $error("error left without acknowledge");
	led_green_a: assert property (led_green_o |-> $past(led_ctrl_i[0])
		&& !$past(interlock_error_o) && !$past(ctrl_error_i)) else $error("green led wrong");
	led_red_a: assert property (led_red_o |-> $past(led_ctrl_i[1])
		&& ($past(interlock_error_o) || $past(ctrl_error_i))) else $error("red led wrong");
	tick_space_a: assert property ({digital_input_word_o, out_applied_o} != prev
		|-> still >= TICK_CYCLES - 1) else $error("update between sample ticks");
endmodule
bind dior_top dior_assertions #(.TICK_CYCLES(TICK_CYCLES), .NUM_OUT(NUM_OUT)) u_chk (
	.ref_clk_i, .rst_b_i, .in_func_en_i, .fault_reaction_option_i, .fault_ack_i,
	.ctrl_error_i, .led_ctrl_i, .digital_input_word_o, .motion_permit_o, .interlock_error_o,
	.fault_trigger_o, .fault_reaction_o, .out_applied_o, .brake_o, .out_pin_o,
	.out_pin_oe_o, .led_green_o, .led_red_o);
`default_nettype wire

// file: testbench/dior_top_tb.sv
// Purpose: self-checking bench for the routing block
// Assumes: short tick of 8 cycles, led half period 2 ticks
// Notes: a 32-cycle wait covers the worst input latency
`timescale 1ns/1ps
`default_nettype none
module dior_top_tb;
	logic ref_clk_i = 1'b0, rst_b_i = 1'b0, fault_ack_i = 1'b0, ctrl_error_i = 1'b0;
	logic in_route_en_i = 1'b0, out_route_en_i = 1'b0, net_active_i;
	logic [255:0] input_source_selectors_i = 256'h0;
	logic [15:0] in_func_en_i = 16'h0000, fault_reaction_option_i = 16'h0000, phys_in_i;
	logic [31:0] digital_output_word_i = 32'h0, out_polarity_i = 32'h0, out_force_en_i = 32'h0;
	logic [31:0] out_force_val_i = 32'h0, output_route_selectors_i = 32'h0;
	logic [31:0] digital_input_word_o, out_applied_o;
	logic [22:0] lvl = 23'h0;
	logic [15:0] fault_reaction_o;
	logic [2:0] hall_in_i, enc_in_i;
	logic [1:0] led_ctrl_i = 2'h0, out_pin_o, out_pin_oe_o, pin_lvl;
	logic motion_permit_o, interlock_error_o, fault_trigger_o, brake_o, led_green_o, led_red_o;
	int failures = 0, compares = 0, cycles = 0, trig = 0, gr = 0, rd = 0;
	logic [7:0] codes [32] = '{8'h00, 8'h80, 8'h01, 8'h10, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45,
		8'h46, 8'h48, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC8, 8'h81, 8'h90, 8'h20,
		8'hA0, 8'h7F, 8'hFF, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
	dior_top #(.TICK_CYCLES(8), .LED_HALF_TICKS(2), .NUM_OUT(2)) dut (.ref_clk_i, .rst_b_i,
		.phys_in_i, .hall_in_i, .enc_in_i, .net_active_i, .in_route_en_i,
		.input_source_selectors_i, .in_func_en_i, .fault_reaction_option_i, .fault_ack_i,
		.ctrl_error_i, .digital_output_word_i, .out_polarity_i, .out_force_en_i,
		.out_force_val_i, .out_route_en_i, .output_route_selectors_i, .led_ctrl_i,
		.digital_input_word_o, .motion_permit_o, .interlock_error_o, .fault_trigger_o,
		.fault_reaction_o, .out_applied_o, .brake_o, .out_pin_o, .out_pin_oe_o,
		.led_green_o, .led_red_o);
	dior_pins_model pins (.lvl_i(lvl), .pin_i(out_pin_o), .pin_oe_i(out_pin_oe_o),
		.phys_o(phys_in_i), .hall_o(hall_in_i), .enc_o(enc_in_i), .net_o(net_active_i),
		.pin_lvl_o(pin_lvl));
	////////////////////////////////
	always #5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		cycles++;
		if (fault_trigger_o === 1'b1) trig++;
		if ($rose(led_green_o)) gr++;
		if ($rose(led_red_o)) rd++;
		// run needs about 1100 cycles
		if (cycles == 20000) begin
			failures++;
			report_and_stop();
		end
	end
	task report_and_stop;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task settle;
		repeat (32) @(negedge ref_clk_i);
	endtask
	function logic src(input logic [7:0] c);
		logic [6:0] b;
		b = c[6:0];
		if (b == 7'h00) return c[7];
		if (b <= 7'h10) return lvl[b - 7'h01] ^ c[7];
		if (b >= 7'h41 && b <= 7'h46) return lvl[b - 7'h31] ^ c[7];
		if (b == 7'h48) return lvl[22] ^ c[7];
		return 1'b0;
	endfunction
	////////////////////////////////
	task t_fixed;
		in_func_en_i = 16'h0007;
		lvl = 23'h00A5C3;
		settle();
		chk("fixed word", digital_input_word_o, {lvl[15:0], lvl[15:0] & in_func_en_i});
	endtask
	task t_xbar;
		logic [31:0] e;
		in_func_en_i = 16'h0000;
		in_route_en_i = 1'b1;
		for (int i = 0; i < 32; i++) input_source_selectors_i[8*i +: 8] = codes[i];
		for (int p = 0; p < 2; p++) begin
			lvl = p ? 23'h54A5E3 : 23'h2B5A1C;
			settle();
			for (int i = 0; i < 32; i++) e[i] = src(codes[i]);
			chk("routed word", digital_input_word_o, e);
		end
	endtask
	task t_interlock;
		int t0;
		input_source_selectors_i[31:24] = 8'h04;
		fault_reaction_option_i = 16'h5A3C;
		lvl = 23'h000008;
		// the release must reach bit 3 before arming, or the old level trips it
		settle();
		in_func_en_i = 16'h0008;
		settle();
		chk("permit", motion_permit_o, 32'h1);
		t0 = trig;
		lvl = 23'h0;
		settle();
		chk("error", {motion_permit_o, interlock_error_o}, 32'h1);
		chk("reaction", fault_reaction_o, 32'h5A3C);
		chk("trigger count", 32'(trig - t0), 32'h1);
		lvl = 23'h000008;
		settle();
		chk("error held", interlock_error_o, 32'h1);
		fault_ack_i = 1'b1;
		settle();
		fault_ack_i = 1'b0;
		chk("error cleared", {motion_permit_o, interlock_error_o}, 32'h2);
		lvl = 23'h0;
		repeat (3) @(negedge ref_clk_i);
		lvl = 23'h000008;
		settle();
		chk("glitch ignored", interlock_error_o, 32'h0);
		in_func_en_i = 16'h0000;
		lvl = 23'h0;
		settle();
		chk("interlock off", interlock_error_o, 32'h0);
	endtask
	task t_outputs;
		logic [31:0] e;
		logic [31:0] tw [4] = '{32'h00010001, 32'h00030000, 32'h00020001, 32'hFFFCFFFE};
		logic [31:0] tp [4] = '{32'h0, 32'h00020001, 32'h0, 32'h00000001};
		logic [31:0] tf [4] = '{32'h0, 32'h0, 32'h00010001, 32'h00020000};
		logic [31:0] tv [4] = '{32'h0, 32'h0, 32'h00010000, 32'h0};
		for (int i = 0; i < 4; i++) begin
			digital_output_word_i = tw[i];
			out_polarity_i = tp[i];
			out_force_en_i = tf[i];
			out_force_val_i = tv[i];
			settle();
			e = (((tf[i] & tv[i]) | (~tf[i] & tw[i])) ^ tp[i]) & 32'h00030001;
			chk("applied", out_applied_o, e);
			chk("brake", brake_o, e[0]);
			chk("pin level", pin_lvl, e[17:16]);
		end
	endtask
	task t_route;
		logic [31:0] rs [4] = '{32'h00800005, 32'h00800005, 32'h01850105, 32'h00800005};
		logic [31:0] rw [4] = '{32'h00000020, 32'h00030001, 32'h00000020, 32'h00000020};
		logic [31:0] e;
		out_polarity_i = 32'h0;
		out_force_en_i = 32'h0;
		for (int i = 0; i < 4; i++) begin
			out_route_en_i = (i < 3);
			output_route_selectors_i = rs[i];
			digital_output_word_i = rw[i];
			settle();
			e = rw[i] & 32'h00030001;
			for (int k = 0; k < 2; k++)
				if (i < 3) e[16+k] = (rs[i][16*k+8 +: 8] == 8'h00) &
					(rw[i][rs[i][16*k +: 5]] ^ rs[i][16*k+7]);
			chk("routed applied", out_applied_o, e);
		end
	endtask
	task led_case(input logic [1:0] c, input logic err, input int eg, input int er);
		int g0, r0;
		led_ctrl_i = c;
		ctrl_error_i = err;
		settle();
		g0 = gr;
		r0 = rd;
		// 12 ticks hold exactly 3 blink periods
		repeat (96) @(negedge ref_clk_i);
		chk("green flashes", 32'(gr - g0), 32'(eg));
		chk("red flashes", 32'(rd - r0), 32'(er));
	endtask
	task t_leds;
		led_case(2'h1, 1'b0, 3, 0);
		led_case(2'h2, 1'b0, 0, 0);
		led_case(2'h3, 1'b1, 0, 3);
		led_case(2'h0, 1'b1, 0, 0);
	endtask
	initial begin
		repeat (3) @(negedge ref_clk_i);
		rst_b_i = 1'b1;
		t_fixed();
		t_xbar();
		t_interlock();
		t_outputs();
		t_route();
		t_leds();
		report_and_stop();
	end
endmodule
`default_nettype wire
